// >>> spfla_consts.svh
`ifndef SPFLA_CONSTS_SVH
`define SPFLA_CONSTS_SVH
// Pointer values selecting the special bytes
`define SPFLA_Z_FUSE_LOW 16'h0000
`define SPFLA_Z_LOCK 16'h0001
`define SPFLA_Z_FUSE_EXT 16'h0002
`define SPFLA_Z_FUSE_HIGH 16'h0003
// Control register bit positions
`define SPFLA_B_EN 0
`define SPFLA_B_ERS 1
`define SPFLA_B_WRT 2
`define SPFLA_B_LOCK 3
`define SPFLA_B_REEN 4
`define SPFLA_B_BUSY 6
// Windows in CPU cycles
`define SPFLA_LOAD_WIN 3
`define SPFLA_STORE_WIN 4
// Programming time limits in microseconds
`define SPFLA_T_MIN_US 3700
`define SPFLA_T_MAX_US 4500
// RC oscillator ticks per microsecond (1 MHz)
`define SPFLA_RC_PER_US 1
// Region boundary and boot starts (word addresses)
`define SPFLA_NO_READ_WHILE_WRITE_REGION_START 13'h1C00
`define SPFLA_BOOT_11 13'h1F80
`define SPFLA_BOOT_10 13'h1F00
`define SPFLA_BOOT_01 13'h1E00
`define SPFLA_BOOT_00 13'h1C00
// Pointer field positions
`define SPFLA_PAGE_HI 13
`define SPFLA_PAGE_LO 7
`define SPFLA_WORD_HI 6
`define SPFLA_WORD_LO 1
`endif

// >>> spfla_pkg.sv
`default_nettype none
package spfla_pkg;
   // Operation kinds carried from control write to store
   typedef enum logic [2:0] {
      SPFLA_OP_NONE, SPFLA_OP_LOAD, SPFLA_OP_ERASE, SPFLA_OP_WRITE,
      SPFLA_OP_LOCK, SPFLA_OP_REEN
   } spfla_op_t;
endpackage
`default_nettype wire

// >>> spfla_if.sv
`timescale 1ns/10ps
`default_nettype none
// CPU core side and flash sequencer side
interface spfla_if;
   logic ctl_we; // Control register write strobe
   logic [7:0] ctl_wdata; // Control write data
   logic [7:0] ctl_rdata; // Control register read value
   logic store_req; // Store instruction pulse
   logic [15:0] z_ptr; // Pointer register
   logic [15:0] store_data; // R1:R0 for store
   logic load_req; // Load-program instruction pulse
   logic [7:0] load_data; // Byte returned to destination
   logic load_valid; // Load answer pulse
   logic [12:0] fetch_addr; // Instruction fetch word address
   logic fetch_blocked; // Fetch refused this cycle
   modport dev (input ctl_we, ctl_wdata, store_req, z_ptr, store_data,
      load_req, fetch_addr, output ctl_rdata, load_data, load_valid,
      fetch_blocked);
   modport cpu (output ctl_we, ctl_wdata, store_req, z_ptr, store_data,
      load_req, fetch_addr, input ctl_rdata, load_data, load_valid,
      fetch_blocked);
endinterface // spfla_if
`default_nettype wire

// >>> spfla_prog_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "spfla_consts.svh"
// Times one flash write on the RC oscillator tick
module spfla_prog_timer #(
   parameter int PROG_US = (`SPFLA_T_MIN_US + `SPFLA_T_MAX_US) / 2
) (
   input wire logic pclk, // CPU clock
   input wire logic presetn, // Power-on reset, active low
   input wire logic rc_tick, // Synchronised RC oscillator tick
   input wire logic start, // Start pulse
   output logic busy // High while programming
);
   localparam int TICKS = PROG_US * `SPFLA_RC_PER_US;
   logic [15:0] cnt_r, cnt_nxt; // Remaining RC ticks
   // Counts only RC ticks, so CPU clock rate does not change the time
   always_comb begin
      cnt_nxt = cnt_r;
      if (start) begin
         cnt_nxt = 16'(TICKS);
      end else if (rc_tick && cnt_r != 16'h0000) begin
         cnt_nxt = cnt_r - 16'h0001;
      end
   end
   // Only power-on reset clears it: system reset lets a write finish
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_r <= 16'h0000;
      else cnt_r <= cnt_nxt;
   end
   assign busy = (cnt_r != 16'h0000);
endmodule // spfla_prog_timer
`default_nettype wire

// >>> spfla_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "spfla_consts.svh"
// How it works
// - Pointer 0x0001 plus lock select reads lock
// - Select bits self-clear on read or timeout
// - Without select bits, load reads program memory
// - Pointer 0x0000 returns low fuse byte
// - Pointer 0x0003 returns high fuse byte
// - Pointer 0x0002 returns extended fuse byte
// - Programmed bits read zero, unprogrammed one
// - Reset lets running write finish
// - Writes timed from RC oscillator, 3.7-4.5ms
// - Boot size fuse picks boot start address
// - READ_WHILE_WRITE_REGION below 0x1C00, NO_READ_WHILE_WRITE_REGION from 0x1C00
// - Thirteen-bit counter, 64-word pages
// - Page number from pointer bits 13:7
// - Pointer bits 6:1 pick buffer word
// - Pointer bits 15:14 ignored, bit0 byte select
// - During programming of its pages READ_WHILE_WRITE_REGION region fetch blocked
// - Software waits idle, masks interrupts
// - Store enable opens four-cycle store window
// - READ_WHILE_WRITE_REGION busy flag set, cleared by reenable/load
module spfla_dev #(
   parameter int PROG_US = (`SPFLA_T_MIN_US + `SPFLA_T_MAX_US) / 2
) (
   input wire logic pclk, // CPU clock
   input wire logic presetn, // Power-on reset, active low
   input wire logic sys_resetn, // System reset, active low
   spfla_if.dev bus, // CPU core side
   input wire logic rc_clk_pin, // Calibrated RC oscillator
   input wire logic [7:0] fuse_low_byte, // Low fuse, 0 = programmed
   input wire logic [7:0] fuse_high_byte, // High fuse
   input wire logic [7:0] extended_fuse_byte, // Extended fuse
   input wire logic [1:0] boot_size_fuse, // Boot size code
   input wire logic eeprom_write_busy, // EEPROM write running
   input wire logic [7:0] prog_rdata, // Flash byte at load address
   output logic [15:0] prog_raddr, // Flash byte address for load
   output logic [12:0] boot_reset_addr, // Boot reset word address
   output logic flash_we, // Buffer word load pulse
   output logic [5:0] word_in_page_field, // Buffer word index
   output logic [15:0] flash_wdata, // Buffer word data
   output logic flash_erase, // Page erase start pulse
   output logic flash_write, // Page write start pulse
   output logic [6:0] page_number_field, // Latched page
   output logic buf_clear // Temporary buffer erase pulse
);
   logic [7:0] lock_r, lock_nxt; // Lock byte, 1 = unprogrammed
   logic [2:0] win_r, win_nxt; // Cycles left in store window
   logic [1:0] lwin_r, lwin_nxt; // Cycles left in load window
   spfla_pkg::spfla_op_t op_r, op_nxt; // Armed operation
   logic rww_busy_flag_r, rww_busy_nxt; // READ_WHILE_WRITE_REGION region busy
   logic prog_rww_r, prog_rww_nxt; // Running op targets READ_WHILE_WRITE_REGION
   logic [6:0] page_r, page_nxt; // Latched page number
   logic [7:0] ld_data_r, ld_data_nxt; // Load answer data
   logic ld_v_r, ld_v_nxt; // Load answer valid
   logic [2:0] rc_sync_r; // RC synchroniser and edge stage
   logic busy; // Programming in progress
   logic start; // Timer start
   logic store_go; // Store accepted in window
   logic lock_arm; // Lock-select read window open

   // Boot start word address from the size code
   function automatic logic [12:0] boot_start(input logic [1:0] c);
      case (c)
         2'h3: boot_start = `SPFLA_BOOT_11;
         2'h2: boot_start = `SPFLA_BOOT_10;
         2'h1: boot_start = `SPFLA_BOOT_01;
         default: boot_start = `SPFLA_BOOT_00;
      endcase
   endfunction

   // Word address below the boundary lies in the READ_WHILE_WRITE_REGION region
   function automatic logic in_rww(input logic [12:0] a);
      in_rww = (a < `SPFLA_NO_READ_WHILE_WRITE_REGION_START);
   endfunction

   // RC oscillator is foreign: two flops, then edge detect on stages 1/2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rc_sync_r <= 3'h0;
      else rc_sync_r <= {rc_sync_r[1:0], rc_clk_pin};
   end

   spfla_prog_timer #(.PROG_US(PROG_US)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .rc_tick(rc_sync_r[1] & ~rc_sync_r[2]),
      .start(start),
      .busy(busy)
   );

   assign store_go = bus.store_req && win_r != 3'h0;
   assign lock_arm = (op_r == spfla_pkg::SPFLA_OP_LOCK) && lwin_r != 2'h0;
   assign start = store_go && (op_r == spfla_pkg::SPFLA_OP_ERASE ||
      op_r == spfla_pkg::SPFLA_OP_WRITE || op_r == spfla_pkg::SPFLA_OP_LOCK);

   // Sequencer next state
   always_comb begin
      win_nxt = win_r;
      lwin_nxt = lwin_r;
      op_nxt = op_r;
      lock_nxt = lock_r;
      rww_busy_nxt = rww_busy_flag_r;
      prog_rww_nxt = prog_rww_r;
      page_nxt = page_r;
      ld_v_nxt = 1'b0;
      ld_data_nxt = ld_data_r;
      if (win_r != 3'h0) win_nxt = win_r - 3'h1;
      if (lwin_r != 2'h0) lwin_nxt = lwin_r - 2'h1;
      if (win_r == 3'h1 && !store_go && !busy)
         op_nxt = spfla_pkg::SPFLA_OP_NONE;
      if (op_r == spfla_pkg::SPFLA_OP_LOCK && lwin_r == 2'h1 && !store_go)
         op_nxt = spfla_pkg::SPFLA_OP_NONE;
      // Control write with enable opens windows unless busy, an op is armed or EEPROM writing
      if (bus.ctl_we && bus.ctl_wdata[`SPFLA_B_EN] && !busy &&
          op_r == spfla_pkg::SPFLA_OP_NONE && !eeprom_write_busy) begin
         win_nxt = 3'(`SPFLA_STORE_WIN);
         lwin_nxt = 2'(`SPFLA_LOAD_WIN);
         case (bus.ctl_wdata[4:1])
            4'h0: op_nxt = spfla_pkg::SPFLA_OP_LOAD;
            4'h1: op_nxt = spfla_pkg::SPFLA_OP_ERASE;
            4'h2: op_nxt = spfla_pkg::SPFLA_OP_WRITE;
            4'h4: op_nxt = spfla_pkg::SPFLA_OP_LOCK;
            4'h8: op_nxt = spfla_pkg::SPFLA_OP_REEN;
            default: begin
               op_nxt = spfla_pkg::SPFLA_OP_NONE; // Other combos ignored
               win_nxt = 3'h0;
               lwin_nxt = 2'h0;
            end
         endcase
      end
      // Lock/fuse read consumes the window
      if (bus.load_req && lock_arm) begin
         ld_v_nxt = 1'b1;
         case (bus.z_ptr[1:0])
            2'h0: ld_data_nxt = fuse_low_byte;
            2'h1: ld_data_nxt = lock_r;
            2'h2: ld_data_nxt = extended_fuse_byte;
            default: ld_data_nxt = fuse_high_byte;
         endcase
         op_nxt = spfla_pkg::SPFLA_OP_NONE;
         win_nxt = 3'h0;
         lwin_nxt = 2'h0;
      end else if (bus.load_req) begin
         ld_v_nxt = 1'b1;
         ld_data_nxt = prog_rdata;
      end
      // Accepted store
      if (store_go) begin
         win_nxt = 3'h0;
         lwin_nxt = 2'h0;
         case (op_r)
            spfla_pkg::SPFLA_OP_LOAD: begin
               rww_busy_nxt = 1'b0;
               op_nxt = spfla_pkg::SPFLA_OP_NONE;
            end
            spfla_pkg::SPFLA_OP_ERASE, spfla_pkg::SPFLA_OP_WRITE: begin
               page_nxt = bus.z_ptr[`SPFLA_PAGE_HI:`SPFLA_PAGE_LO];
               prog_rww_nxt = in_rww({page_nxt, 6'h00});
               if (prog_rww_nxt) rww_busy_nxt = 1'b1;
            end
            spfla_pkg::SPFLA_OP_LOCK: begin
               prog_rww_nxt = 1'b0; // Whole flash readable
               lock_nxt = lock_r & {2'h3, bus.store_data[5:2], 2'h3};
            end
            spfla_pkg::SPFLA_OP_REEN: begin
               rww_busy_nxt = 1'b0;
               op_nxt = spfla_pkg::SPFLA_OP_NONE;
            end
            default: op_nxt = spfla_pkg::SPFLA_OP_NONE;
         endcase
      end
      // Programming done releases the enable
      if (!busy && !start && win_r == 3'h0 &&
          (op_r == spfla_pkg::SPFLA_OP_ERASE ||
           op_r == spfla_pkg::SPFLA_OP_WRITE ||
           op_r == spfla_pkg::SPFLA_OP_LOCK) && lwin_r == 2'h0)
         op_nxt = spfla_pkg::SPFLA_OP_NONE;
   end

   // Lock byte and READ_WHILE_WRITE_REGION flag survive system reset; power-on clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_r <= 8'hFF;
         rww_busy_flag_r <= 1'b0;
         prog_rww_r <= 1'b0;
         page_r <= 7'h00;
      end else begin
         lock_r <= lock_nxt;
         rww_busy_flag_r <= rww_busy_nxt;
         prog_rww_r <= prog_rww_nxt;
         page_r <= page_nxt;
      end
   end

   // CPU-facing state; system reset drops windows but not a busy write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_r <= 3'h0;
         lwin_r <= 2'h0;
         op_r <= spfla_pkg::SPFLA_OP_NONE;
         ld_data_r <= 8'h00;
         ld_v_r <= 1'b0;
      end else if (!sys_resetn && !busy) begin
         win_r <= 3'h0;
         lwin_r <= 2'h0;
         op_r <= spfla_pkg::SPFLA_OP_NONE;
         ld_data_r <= 8'h00;
         ld_v_r <= 1'b0;
      end else begin
         win_r <= win_nxt;
         lwin_r <= lwin_nxt;
         op_r <= op_nxt;
         ld_data_r <= ld_data_nxt;
         ld_v_r <= ld_v_nxt;
      end
   end

   // Control register readback, reserved bit 5 reads zero
   always_comb begin
      bus.ctl_rdata = 8'h00;
      bus.ctl_rdata[`SPFLA_B_BUSY] = rww_busy_flag_r;
      bus.ctl_rdata[`SPFLA_B_REEN] = (op_r == spfla_pkg::SPFLA_OP_REEN);
      bus.ctl_rdata[`SPFLA_B_LOCK] = (op_r == spfla_pkg::SPFLA_OP_LOCK);
      bus.ctl_rdata[`SPFLA_B_WRT] = (op_r == spfla_pkg::SPFLA_OP_WRITE);
      bus.ctl_rdata[`SPFLA_B_ERS] = (op_r == spfla_pkg::SPFLA_OP_ERASE);
      bus.ctl_rdata[`SPFLA_B_EN] = (op_r != spfla_pkg::SPFLA_OP_NONE);
   end

   assign bus.load_data = ld_data_r;
   assign bus.load_valid = ld_v_r;
   // READ_WHILE_WRITE_REGION fetch refused while programming it, or until re-enabled
   assign bus.fetch_blocked = in_rww(bus.fetch_addr) &&
      rww_busy_flag_r;
   assign prog_raddr = {2'h0, bus.z_ptr[13:0]};
   assign boot_reset_addr = boot_start(boot_size_fuse);
   assign flash_we = store_go && op_r == spfla_pkg::SPFLA_OP_LOAD;
   assign word_in_page_field =
      bus.z_ptr[`SPFLA_WORD_HI:`SPFLA_WORD_LO];
   assign flash_wdata = bus.store_data;
   assign flash_erase = store_go && op_r == spfla_pkg::SPFLA_OP_ERASE;
   assign flash_write = store_go && op_r == spfla_pkg::SPFLA_OP_WRITE;
   assign page_number_field = page_r;
   assign buf_clear = flash_write ||
      (store_go && op_r == spfla_pkg::SPFLA_OP_REEN);
endmodule // spfla_dev
`default_nettype wire

// >>> spfla_cpu.sv
`timescale 1ns/10ps
`default_nettype none
`include "spfla_consts.svh"
// CPU end: APB slave registers drive the core's flash instructions
module spfla_cpu (
   input wire logic pclk, // CPU clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [3:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   spfla_if.cpu bus // Sequencer side
);
   localparam logic [3:0] A_CMD = 4'h0; // Bits 7:0 ctl, 8 store, 9 load
   localparam logic [3:0] A_PTR = 4'h4; // 15:0 pointer, 31:16 data
   localparam logic [3:0] A_STAT = 4'h8; // 7:0 ctl, 15:8 load, 16 refused
   logic [31:0] ptr_r, ptr_nxt; // Pointer and store data
   logic [7:0] res_r, res_nxt; // Last load answer
   logic acc; // Access phase
   assign acc = psel && penable;
   // Latch pointer writes and load answers
   always_comb begin
      ptr_nxt = ptr_r;
      res_nxt = res_r;
      if (acc && pwrite && paddr == A_PTR) ptr_nxt = pwdata;
      if (bus.load_valid) res_nxt = bus.load_data;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_r <= 32'h0000_0000;
         res_r <= 8'h00;
      end else begin
         ptr_r <= ptr_nxt;
         res_r <= res_nxt;
      end
   end
   // Command word issues control write, store and load in the same cycle
   assign bus.ctl_we = acc && pwrite && paddr == A_CMD &&
      pwdata[7:0] != 8'h00;
   assign bus.ctl_wdata = pwdata[7:0];
   assign bus.store_req = acc && pwrite && paddr == A_CMD && pwdata[8];
   assign bus.load_req = acc && pwrite && paddr == A_CMD && pwdata[9];
   assign bus.z_ptr = ptr_r[15:0];
   assign bus.store_data = ptr_r[31:16];
   // Fetch follows the pointer word, so software can probe either region
   assign bus.fetch_addr = ptr_r[13:1];
   assign pready = 1'b1; // Zero wait states
   assign pslverr = psel && penable && paddr != A_CMD &&
      paddr != A_PTR && paddr != A_STAT;
   // Read mux
   always_comb begin
      case (paddr)
         A_PTR: prdata = ptr_r;
         A_STAT: prdata = {15'h0000, bus.fetch_blocked, res_r,
            bus.ctl_rdata};
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule // spfla_cpu
`default_nettype wire

// >>> spfla_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the link between the core end and the flash sequencer end
module spfla_properties (
   input wire logic pclk, // CPU clock
   input wire logic presetn, // Reset, active low
   input wire logic ctl_we, // Control write strobe
   input wire logic [7:0] ctl_rdata, // Control status
   input wire logic store_req, // Store pulse
   input wire logic [15:0] z_ptr, // Pointer
   input wire logic load_req, // Load pulse
   input wire logic [7:0] load_data, // Load answer byte
   input wire logic load_valid, // Load answer strobe
   input wire logic [12:0] fetch_addr, // Fetch word address
   input wire logic fetch_blocked // Fetch refused
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Each load answered on the next edge, never unasked
   a_load_answer: assert property (load_valid == $past(load_req))
      else $error("load answer timing wrong");
   // Lock byte is unprogrammed after power-on, so all ones
   a_lock_value: assert property (load_req && ctl_rdata[3] && ctl_rdata[0]
      && z_ptr[13:0] == 14'h0001 |=> load_data == 8'hFF)
      else $error("lock byte read wrong");
   // Lock select drops soon after a lock read
   a_lock_clear: assert property (load_req && ctl_rdata[3] && ctl_rdata[0]
      |-> ##[1:4] !ctl_rdata[3])
      else $error("lock select not cleared");
   // No store in the window: enable falls right after its last cycle
   a_store_window: assert property ($rose(ctl_rdata[0]) && !store_req
      ##1 !store_req [*3] |=> !ctl_rdata[0])
      else $error("store enable outlived window");
   // Programming keeps enable up for eight cycles after the busy flag rises
   a_busy_stays: assert property ($rose(ctl_rdata[6])
      |-> ctl_rdata[0] [*8])
      else $error("programming ended too soon");
   // Busy flag only drops on a control write or a store
   a_rww_hold: assert property (ctl_rdata[6] && !ctl_we && !store_req
      |=> ctl_rdata[6])
      else $error("region busy flag dropped alone");
   // Region below the boundary is blocked while busy
   a_fetch_block: assert property (ctl_rdata[6]
      && fetch_addr < 13'h1C00 |-> fetch_blocked)
      else $error("fetch not blocked while busy");
   // Idle sequencer never blocks fetch
   a_fetch_free: assert property (!ctl_rdata[6] && !ctl_rdata[0]
      |-> !fetch_blocked)
      else $error("fetch blocked while idle");
   // Boot region stays readable whatever is being programmed
   a_no_read_while_write_region_free: assert property (fetch_addr >= 13'h1C00
      |-> !fetch_blocked)
      else $error("boot region fetch blocked");
   cover property (load_req && ctl_rdata[3]);
   cover property ($rose(ctl_rdata[6]));
   cover property ($fell(ctl_rdata[6]));
endmodule // spfla_properties
`default_nettype wire

// >>> test_self_program_fuse_lock_access.sv
`timescale 1ns/10ps
`default_nettype none
module test_self_program_fuse_lock_access;
   localparam int PROG = 5; // Short programming time, in RC ticks
   typedef struct packed {
      logic [2:0] kind;
      logic [31:0] val;
      logic [31:0] mask;
   } spfla_exp_t;
   logic pclk, presetn, sys_resetn, psel, penable, pwrite, pready, pslverr;
   logic [3:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic rc_clk_pin, eeprom_write_busy, flash_we, flash_erase, flash_write;
   logic buf_clear, pslverr_seen; // Buffer erase pulse, unmapped error
   logic [7:0] fz [4]; // Fuse and lock table indexed by pointer
   logic [7:0] prog_rdata;
   logic [15:0] prog_raddr, flash_wdata, z, d;
   logic [12:0] boot_reset_addr;
   logic [1:0] boot_size_fuse;
   logic [5:0] word_in_page_field, w;
   logic [6:0] page_number_field, p;
   int seed, miscompares, comparisons, n, el, clears;
   realtime t0;
   spfla_exp_t exp_q[$]; // Expected results, oldest first
   spfla_if bus_if();
   spfla_cpu spfla_cpu_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
   spfla_dev #(.PROG_US(PROG)) spfla_dev_inst (.pclk(pclk),
      .presetn(presetn), .sys_resetn(sys_resetn), .bus(bus_if),
      .rc_clk_pin(rc_clk_pin), .fuse_low_byte(fz[0]),
      .fuse_high_byte(fz[3]), .extended_fuse_byte(fz[2]),
      .boot_size_fuse(boot_size_fuse), .eeprom_write_busy(eeprom_write_busy),
      .prog_rdata(prog_rdata), .prog_raddr(prog_raddr),
      .boot_reset_addr(boot_reset_addr), .flash_we(flash_we),
      .word_in_page_field(word_in_page_field), .flash_wdata(flash_wdata),
      .flash_erase(flash_erase), .flash_write(flash_write),
      .page_number_field(page_number_field), .buf_clear(buf_clear));
   spfla_properties spfla_properties_inst (.pclk(pclk), .presetn(presetn),
      .ctl_we(bus_if.ctl_we), .ctl_rdata(bus_if.ctl_rdata),
      .store_req(bus_if.store_req), .z_ptr(bus_if.z_ptr),
      .load_req(bus_if.load_req), .load_data(bus_if.load_data),
      .load_valid(bus_if.load_valid), .fetch_addr(bus_if.fetch_addr),
      .fetch_blocked(bus_if.fetch_blocked));
   // Flash array stand-in: byte is a hash of its address
   assign prog_rdata = prog_raddr[7:0] ^ prog_raddr[15:8] ^ 8'hA5;
   function automatic logic [7:0] mem(input logic [15:0] a);
      return a[7:0] ^ {2'b00, a[13:8]} ^ 8'hA5;
   endfunction
   // Clocks: RC offset so its edges never meet the CPU clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      rc_clk_pin = 1'b0;
      #7;
      forever #500 rc_clk_pin = ~rc_clk_pin;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // Oldest note must match the result that just appeared
   task automatic take(input logic [2:0] k, input logic [31:0] got);
      spfla_exp_t e;
      if (exp_q.size() == 0) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, 32'h0);
      end else begin
         e = exp_q.pop_front();
         check({29'h0, k}, {29'h0, e.kind});
         check(got & e.mask, e.val & e.mask);
      end
   endtask
   // Result monitor, sampling pre-edge values
   always @(posedge pclk) begin
      if (presetn === 1'b1) begin
         if (bus_if.load_valid === 1'b1) take(3'd0, {24'h0, bus_if.load_data});
         if (flash_we === 1'b1) take(3'd1, {10'h0, word_in_page_field,
            flash_wdata});
         if (flash_erase === 1'b1) take(3'd2, 32'h0);
         if (flash_write === 1'b1) take(3'd3, 32'h0);
         if (buf_clear === 1'b1) clears++;
         if (psel && penable && pready === 1'b1 && !pwrite) take(3'd4, prdata);
      end
   end
   // One APB transfer; gap idle cycles first, else back to back
   task automatic apb(input logic [3:0] a, input logic [31:0] dv,
      input logic wv, input int gap, output logic [31:0] rv, output logic e);
      if (gap > 0) begin
         psel <= 1'b0;
         penable <= 1'b0;
         repeat (gap) @(posedge pclk);
      end
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wv;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits for ready however long; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      e = pslverr;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] dv, input int g);
      logic [31:0] rv;
      logic e;
      apb(a, dv, 1'b1, g, rv, e);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] v,
      input logic [31:0] m, input int g, output logic [31:0] rv);
      logic e;
      exp_q.push_back({3'd4, v, m});
      apb(a, 32'h0, 1'b0, g, rv, e);
   endtask
   task automatic conclude();
      $display("Counts: %0d comparisons, %0d miscompares", comparisons,
         miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog, well beyond the expected run of a few hundred cycles
   initial begin
      #400000;
      miscompares++;
      conclude();
   end
   // Main sequence
   initial begin
      seed = 502;
      miscompares = 0;
      comparisons = 0;
      clears = 0;
      presetn = 1'b0;
      sys_resetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      eeprom_write_busy = 1'b0;
      boot_size_fuse = 2'b11;
      fz[0] = 8'($random(seed));
      fz[1] = 8'hFF;
      fz[2] = 8'($random(seed));
      fz[3] = 8'($random(seed));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      sys_resetn <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         boot_size_fuse <= 2'(b);
         @(posedge pclk);
         check({19'h0, boot_reset_addr}, {18'h0, 14'h2000 - (14'h400 >> b)});
      end
      $display("Test boot_start done");
      // Special bytes; odd pointers load one cycle later
      for (int i = 0; i < 4; i++) begin
         z = {2'($random(seed)), 12'h000, 2'(i)};
         wr(4'h4, {16'h0, z}, 0);
         wr(4'h0, 32'h09, 0);
         exp_q.push_back({3'd0, 24'h0, fz[i], 32'hFF});
         wr(4'h0, 32'h200, i % 2);
         rd(4'h8, 32'h0, 32'h1F, 1, r);
      end
      $display("Test fuse_lock_read done");
      // Expired window, blocked arm, unarmed loads: plain reads
      for (int k = 0; k < 4; k++) begin
         z = (k < 2) ? 16'h0001 : 16'($random(seed));
         eeprom_write_busy <= (k == 1);
         wr(4'h4, {16'h0, z}, 1);
         if (k < 2) wr(4'h0, 32'h09, 0);
         exp_q.push_back({3'd0, 24'h0, mem(z), 32'hFF});
         wr(4'h0, 32'h200, (k == 0) ? 2 : 0);
      end
      eeprom_write_busy <= 1'b0;
      $display("Test plain_read done");
      // Store on the last window cycle, then one cycle late
      for (int g = 2; g < 4; g++) begin
         w = 6'($random(seed));
         d = 16'($random(seed));
         wr(4'h4, {d, 9'h0, w, 1'b0}, 1);
         wr(4'h0, 32'h01, 0);
         if (g == 2) exp_q.push_back({3'd1, 10'h0, w, d, 32'h3FFFFF});
         wr(4'h0, 32'h100, g);
      end
      $display("Test store_window done");
      // Erase in the shared region, write in the NO_READ_WHILE_WRITE_REGION region
      for (int k = 0; k < 2; k++) begin
         p = (k == 0) ? 7'($random(seed) & 32'h3F) : 7'h70 | 7'($random(seed) & 32'hF);
         wr(4'h4, {16'h0, 2'b11, p, 7'h0}, 1);
         wr(4'h0, (k == 0) ? 32'h03 : 32'h05, 0);
         exp_q.push_back({3'(2 + k), 64'h0});
         wr(4'h0, 32'h100, 0);
         t0 = $realtime;
         rd(4'h8, {15'h0, k == 0, 9'h0, k == 0, 5'h0, 1'b1}, 32'h1_0041, 1,
            r);
         n = 0;
         do begin
            sys_resetn <= !(k == 0 && n == 0);
            rd(4'h8, 32'h0, 32'h0, 1, r);
            n++;
         end while (r[0] === 1'b1 && n < 200);
         el = int'(($realtime - t0) / 50.0);
         check(32'(el >= (PROG - 1) * 20 && el <= (PROG + 2) * 20), 32'h1);
         check({25'h0, page_number_field}, {25'h0, p});
         rd(4'h8, {15'h0, k == 0, 9'h0, k == 0, 6'h0}, 32'h1_0041, 1,
            r);
         wr(4'h0, 32'h11, 1);
         wr(4'h0, 32'h100, 0);
         rd(4'h8, 32'h0, 32'h1_0041, 1, r);
      end
      $display("Test programming done");
      // Two op bits at once are ignored; the store after it does nothing
      wr(4'h0, 32'h07, 1);
      wr(4'h0, 32'h100, 0);
      rd(4'h8, 32'h0, 32'h1F, 0, r);
      apb(4'hC, 32'h0, 1'b1, 1, r, pslverr_seen);
      check({31'h0, pslverr_seen}, 32'h1);
      check(32'(exp_q.size()), 32'h0);
      // One page write and two re-enables each erase the buffer
      check(32'(clears), 32'h3);
      $display("Test unmapped done");
      conclude();
   end
endmodule // test_self_program_fuse_lock_access
`default_nettype wire
